// ==== rtl/pcc_pkg.sv ====
// Package of constants and types for the compare counter core
// Function
// - A 16-bit up-counter with compare values A and B, each with its own shadow.
// - Control bit 3 picks count source: 0 internal divided clock, 1 external input.
// - Internal mode counts at clock divided by two to the divider_code, codes 0 to 0xe.
// - External mode counts once per rising edge of the external count input.
// - External mode matches, reloads and clears exactly like internal mode.
// - Writing 1 to control bit 1 clears the counter to zero.
// - A running counter clears itself on the count tick after it reaches active compare B.
// - Writing the counter register loads that value into the counter.
// - Reading the counter register returns the current count.
// - With shadow writes off, compare addresses reach the active compare values.
// - Control bit 5 routes compare reads and writes to shadows when set.
// - With control bit 5 set, each counter clear copies both shadows into the active compare values.
// - Reset leaves both active compare values and both shadows at zero.
// - A match signal is raised whenever the count equals an active compare value, except in reset and the first clock after it.
// - The count repeats with a period of compare B plus one count cycles.
// - Control bit 0 written 1 starts counting; written 0 stops and keeps the count.
// - Run and clear written together clear first, then counting begins.
// - After a B match counting resumes from zero; an A match never stops it.
package pcc_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRESC_STAGES = 14;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned IDX_W = 15;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CMP_A = 15'h5300;
  localparam logic [IDX_W-1:0] IDX_CMP_B = 15'h5302;
  localparam logic [IDX_W-1:0] IDX_COUNT = 15'h5304;
  localparam logic [IDX_W-1:0] IDX_CTRL = 15'h5306;
  localparam logic [IDX_W-1:0] IDX_DIV = 15'h5308;

  // Control and divider register field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned CTRL_SRC_BIT = 3;
  localparam int unsigned CTRL_SHADOW_BIT = 5;
  localparam int unsigned DIV_LSB = 0;

  // Reset values and the reserved divider code
  localparam logic [CNT_W-1:0] RST_CMP = 16'h0000;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RESERVED = 4'hf;

  typedef enum logic [1:0] {
    PCC_BUS_IDLE = 2'b00,
    PCC_BUS_WRITE = 2'b01,
    PCC_BUS_RDWAIT = 2'b11,
    PCC_BUS_RDDONE = 2'b10
  } pcc_bus_state_t;

endpackage

// ==== rtl/pcc_prescaler.sv ====
// Free-running prescaler giving one-cycle count enables
`timescale 1ns/1ps
module pcc_prescaler
  import pcc_pkg::*;
#(
  parameter int unsigned StageCount = PRESC_STAGES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [DIV_W-1:0] divCode,
  output logic tick
);

  typedef struct packed {
    logic [StageCount-1:0] stage;
  } pcc_presc_state_t;

  pcc_presc_state_t s_q;
  pcc_presc_state_t s_d;
  logic [StageCount-1:0] mask;

  // Low divCode bits all ones marks one clock in 2**divCode
  for (genvar i = 0; i < StageCount; i++) begin : gMask
    assign mask[i] = (divCode > DIV_W'(i));
  end

  assign tick = (divCode != DIV_RESERVED) && ((s_q.stage & mask) == mask);

  always_comb begin
    s_d = s_q;
    s_d.stage = StageCount'(s_q.stage + 1'b1);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== rtl/pcc_edge_detect.sv ====
// Synchroniser and rising edge detector for the external count input
`timescale 1ns/1ps
module pcc_edge_detect (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic levelIn,
  output logic rise
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } pcc_edge_state_t;

  pcc_edge_state_t s_q;
  pcc_edge_state_t s_d;

  assign rise = s_q.sync2 & ~s_q.prev;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = levelIn;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== rtl/pcc_timer.sv ====
// Compare counter core with its AHB-Lite register slave
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module pcc_timer
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic externalCountInput,
  output logic matchA,
  output logic matchB,
  output logic [CNT_W-1:0] countValue
);

  typedef struct packed {
    pcc_bus_state_t bus;
    logic [IDX_W-1:0] idx;
    logic inMap;
    logic [31:0] rdata;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmpA;
    logic [CNT_W-1:0] cmpB;
    logic [CNT_W-1:0] shadowA;
    logic [CNT_W-1:0] shadowB;
    logic run;
    logic srcExt;
    logic shadowEn;
    logic [DIV_W-1:0] divCode;
    logic matchA;
    logic matchB;
  } pcc_timer_state_t;

  pcc_timer_state_t s_q;
  pcc_timer_state_t s_d;

  logic prescTick;
  logic extRise;
  logic takeAddr;
  logic doWrite;
  logic [CNT_W-1:0] wdata;
  logic countTick;
  logic clearNow;

  pcc_prescaler #(
    .StageCount(PRESC_STAGES)
  ) u_pcc_prescaler (
    .mclk(mclk),
    .reset_n(reset_n),
    .divCode(s_q.divCode),
    .tick(prescTick)
  );

  pcc_edge_detect u_pcc_edge_detect (
    .mclk(mclk),
    .reset_n(reset_n),
    .levelIn(externalCountInput),
    .rise(extRise)
  );

  // Reads take one wait state so the read data comes from a register
  assign hreadyout = (s_q.bus != PCC_BUS_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign matchA = s_q.matchA;
  assign matchB = s_q.matchB;
  assign countValue = s_q.count;

  assign takeAddr = hsel && htrans[1] && hready;
  assign doWrite = (s_q.bus == PCC_BUS_WRITE) && s_q.inMap;
  assign wdata = hwdata[CNT_W-1:0];

  // Count enable source: external edges never depend on the prescaler
  assign countTick = s_q.run && (s_q.srcExt ? extRise : prescTick);

  function automatic logic [31:0] readMux(input pcc_timer_state_t st);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (!st.inMap) begin
      r = 32'h0000_0000;
    end else if (st.idx == IDX_CMP_A) begin
      r[CNT_W-1:0] = st.shadowEn ? st.shadowA : st.cmpA;
    end else if (st.idx == IDX_CMP_B) begin
      r[CNT_W-1:0] = st.shadowEn ? st.shadowB : st.cmpB;
    end else if (st.idx == IDX_COUNT) begin
      r[CNT_W-1:0] = st.count;
    end else if (st.idx == IDX_CTRL) begin
      r[CTRL_RUN_BIT] = st.run;
      r[CTRL_SRC_BIT] = st.srcExt;
      r[CTRL_SHADOW_BIT] = st.shadowEn;
    end else if (st.idx == IDX_DIV) begin
      r[DIV_LSB +: DIV_W] = st.divCode;
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    clearNow = 1'b0;

    // Bus phase tracking
    case (s_q.bus)
      PCC_BUS_RDWAIT: begin
        s_d.rdata = readMux(s_q);
        s_d.bus = PCC_BUS_RDDONE;
      end
      default: begin
        if (takeAddr) begin
          s_d.idx = haddr[IDX_W+1:2];
          s_d.inMap = (haddr[31:IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
          s_d.bus = hwrite ? PCC_BUS_WRITE : PCC_BUS_RDWAIT;
        end else begin
          s_d.bus = PCC_BUS_IDLE;
        end
      end
    endcase

    // Compare and divider writes
    if (doWrite && (s_q.idx == IDX_CMP_A)) begin
      if (s_q.shadowEn) begin
        s_d.shadowA = wdata;
      end else begin
        s_d.cmpA = wdata;
      end
    end
    if (doWrite && (s_q.idx == IDX_CMP_B)) begin
      if (s_q.shadowEn) begin
        s_d.shadowB = wdata;
      end else begin
        s_d.cmpB = wdata;
      end
    end
    if (doWrite && (s_q.idx == IDX_DIV)) begin
      s_d.divCode = wdata[DIV_LSB +: DIV_W];
    end

    // Counter: control write, then counter load, then counting
    if (doWrite && (s_q.idx == IDX_CTRL)) begin
      s_d.run = wdata[CTRL_RUN_BIT];
      s_d.srcExt = wdata[CTRL_SRC_BIT];
      s_d.shadowEn = wdata[CTRL_SHADOW_BIT];
      if (wdata[CTRL_CLEAR_BIT]) begin
        s_d.count = '0;
        clearNow = 1'b1;
      end
    end else if (doWrite && (s_q.idx == IDX_COUNT)) begin
      s_d.count = wdata;
    end else if (countTick) begin
      if (s_q.count == s_q.cmpB) begin
        s_d.count = '0;
        clearNow = 1'b1;
      end else begin
        s_d.count = CNT_W'(s_q.count + 1'b1);
      end
    end

    // Shadows move to the active values on every clear when enabled
    if (clearNow && s_q.shadowEn) begin
      s_d.cmpA = s_q.shadowA;
      s_d.cmpB = s_q.shadowB;
      if (doWrite && (s_q.idx == IDX_CMP_A)) begin
        s_d.cmpA = s_q.shadowA;
      end
    end

    s_d.matchA = (s_d.count == s_d.cmpA);
    s_d.matchB = (s_d.count == s_d.cmpB);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.bus <= PCC_BUS_IDLE;
      s_q.idx <= '0;
      s_q.inMap <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.count <= RST_COUNT;
      s_q.cmpA <= RST_CMP;
      s_q.cmpB <= RST_CMP;
      s_q.shadowA <= RST_CMP;
      s_q.shadowB <= RST_CMP;
      s_q.run <= 1'b0;
      s_q.srcExt <= 1'b0;
      s_q.shadowEn <= 1'b0;
      s_q.divCode <= RST_DIV;
      s_q.matchA <= 1'b0;
      s_q.matchB <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== test/pcc_timer_properties.sv ====
// Port checker for the compare counter core
`timescale 1ns/1ps
module pcc_timer_properties
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic externalCountInput,
  input wire logic matchA,
  input wire logic matchB,
  input wire logic [CNT_W-1:0] countValue
);
  logic take;
  logic rdTake;
  logic wrPh_q;
  assign take = hsel && htrans[1] && hready;
  assign rdTake = take && !hwrite;
  // Marks a write data phase, whose effect shows one cycle later
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) wrPh_q <= 1'b0;
    else wrPh_q <= take && hwrite;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property (!hreadyout |-> $past(rdTake))
    else $error("stall without read");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
  a_count_step: assert property ($changed(countValue) && !$past(wrPh_q) |->
    countValue == $past(countValue) + 16'h0001 || countValue == 16'h0000)
    else $error("count jumped");
  a_wrap_at_b: assert property ($changed(countValue) && !$past(wrPh_q) &&
    $past(matchB) |-> countValue == 16'h0000)
    else $error("no wrap at compare b");
  a_a_no_stop: assert property ($changed(countValue) && !$past(wrPh_q) &&
    $past(matchA) && !$past(matchB) |-> countValue == $past(countValue) + 16'h0001)
    else $error("compare a disturbed count");
  c_wrap: cover property (matchB ##1 countValue == 16'h0000);
  c_read: cover property (take && !hwrite);
  c_match_a: cover property (matchA && !matchB);
endmodule

// ==== test/tb_top.sv ====
// Bench for the compare counter core
`timescale 1ns/1ps
module tb_top;
  import pcc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic extIn = 1'b0;
  logic hreadyout, hresp, matchA, matchB;
  logic [31:0] hrdata;
  logic [CNT_W-1:0] countValue;
  logic [15:0] rd;
  logic [3:0] dv [4] = '{4'h0, 4'h1, 4'h3, 4'h8};
  int error_cnt = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  pcc_timer u_pcc_timer (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .externalCountInput(extIn),
    .matchA(matchA), .matchB(matchB), .countValue(countValue));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic [IDX_W-1:0] ix, input logic w, input logic [15:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {15'h0000, ix, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata[15:0];
  endtask
  task automatic wr(input logic [IDX_W-1:0] ix, input logic [15:0] d);
    xfer(ix, 1'b1, d);
  endtask
  task automatic rc(input logic [IDX_W-1:0] ix, input logic [15:0] e);
    xfer(ix, 1'b0, 16'h0000);
    chk(rd, e);
  endtask
  // Cycles from one rise of matchB to the next
  task automatic period(input int e);
    int n;
    n = 0;
    while (matchB !== 1'b0) @(posedge mclk);
    while (matchB !== 1'b1) @(posedge mclk);
    while (matchB === 1'b1) begin
      @(posedge mclk);
      n++;
    end
    while (matchB !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    chk(16'(n), 16'(e));
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rc(IDX_CMP_A, 16'h0000);
    rc(IDX_CMP_B, 16'h0000);
    rc(IDX_DIV, 16'h0000);
    rc(IDX_CTRL, 16'h0000);
    rc(15'h530a, 16'h0000);
    wr(IDX_COUNT, 16'h1234);
    repeat (5) @(posedge mclk);
    rc(IDX_COUNT, 16'h1234);
    wr(IDX_CMP_A, 16'h0003);
    wr(IDX_CMP_B, 16'h0005);
    rc(IDX_CMP_B, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 16'h0000);
      wr(IDX_DIV, {12'h000, dv[i]});
      wr(IDX_CTRL, 16'h0003);
      period(6 << dv[i]);
      chk({15'h0, matchA}, {15'h0, countValue == 16'h0003});
      while (countValue !== 16'h0003) @(posedge mclk);
      chk({15'h0, matchA}, 16'h0001);
    end
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_DIV, 16'h000f);
    wr(IDX_COUNT, 16'h0007);
    wr(IDX_CTRL, 16'h0001);
    repeat (40) @(posedge mclk);
    rc(IDX_COUNT, 16'h0007);
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_DIV, 16'h0000);
    wr(IDX_CTRL, 16'h0020);
    wr(IDX_CMP_B, 16'h0009);
    rc(IDX_CMP_B, 16'h0009);
    wr(IDX_CTRL, 16'h0023);
    period(10);
    wr(IDX_CMP_B, 16'h0002);
    period(3);
    wr(IDX_CTRL, 16'h0000);
    rc(IDX_CMP_B, 16'h0002);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CTRL, 16'h0009);
    repeat (5) begin
      extIn <= 1'b1;
      repeat (3) @(posedge mclk);
      extIn <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
    rc(IDX_COUNT, 16'h0002);
    rc(IDX_CTRL, 16'h0009);
    wr(IDX_CTRL, 16'h0008);
    extIn <= 1'b1;
    repeat (3) @(posedge mclk);
    extIn <= 1'b0;
    repeat (6) @(posedge mclk);
    rc(IDX_COUNT, 16'h0002);
    wr(IDX_CTRL, 16'h0002);
    rc(IDX_COUNT, 16'h0000);
    rc(IDX_CTRL, 16'h0000);
    final_report();
  end
endmodule
bind pcc_timer pcc_timer_properties u_pcc_timer_properties (.mclk(mclk), .reset_n(reset_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .externalCountInput(externalCountInput), .matchA(matchA), .matchB(matchB),
  .countValue(countValue));
